// [inc/smsp_regs.vh]
// register map, field positions, reset values and timing constants of the serial module spi port
// Behaviour
// RULE_01 - mode codes 000..100 select master at sys/4, sys/16, sys/64, sub clock, timer/2
// RULE_02 - code 101 spi slave, 110 two-wire slave, 111 unused; resets to 111
// RULE_03 - slave takes its shift clock from the external master, never drives it
// RULE_04 - enable 0 releases all four lines and stops the module logic
// RULE_05 - raising enable leaves control register contents unchanged
// RULE_06 - slave select rising mid-byte sets incomplete and complete flags together
// RULE_07 - interrupt request rises on incomplete condition when its enable is set
// RULE_08 - software writing 1 to incomplete flag never sets complete flag
// RULE_09 - incomplete flag only works in spi slave mode
// RULE_10 - idle level bit 0 holds clock high, 1 holds clock low
// RULE_11 - select enable 1 activates select pin, 0 leaves it floating
// RULE_12 - master starts every transfer and alone drives the clock
// RULE_13 - one eight-bit data register shifts out and in concurrently
// RULE_14 - software loads byte before transfer, reads received byte from same register
// RULE_15 - control 2 bits 7..6 are plain storage, reset 0
// RULE_16 - control 0 bit 4 reads zero
// RULE_17 - debounce bits do not affect spi operation
// RULE_18 - byte completion sets complete flag; only software clears it
// RULE_19 - data write during transfer is discarded and sets collision flag
// RULE_20 - bit order 1 shifts msb first, 0 lsb first
// RULE_21 - edge select with idle level picks rising or falling capture edge
// RULE_22 - master data write starts an eight-clock byte at selected rate
// RULE_23 - slave with select enabled shifts only while select is low
`ifndef SMSP_REGS_VH
`define SMSP_REGS_VH
`define SMSP_OFS_CTRL0 12'h000
`define SMSP_OFS_CTRL2 12'h004
`define SMSP_OFS_DATA 12'h008
`define SMSP_OFS_IEN 12'h00C
`define SMSP_CTRL0_RST 8'hE0
`define SMSP_CTRL2_RST 8'h00
`define SMSP_DATA_RST 8'h00
`define SMSP_MODE_HI 7
`define SMSP_MODE_LO 5
`define SMSP_DEB_HI 3
`define SMSP_DEB_LO 2
`define SMSP_EN_BIT 1
`define SMSP_ICF_BIT 0
`define SMSP_SPARE_HI 7
`define SMSP_SPARE_LO 6
`define SMSP_IDLE_BIT 5
`define SMSP_EDGE_BIT 4
`define SMSP_ORDER_BIT 3
`define SMSP_SELECT_PIN_ENABLE_BIT 2
`define SMSP_WRITE_COLLISION_FLAG_BIT 1
`define SMSP_TRF_BIT 0
`define SMSP_IEN_TRF_BIT 0
`define SMSP_IEN_ICF_BIT 1
`define SMSP_MODE_DIV4 3'h0
`define SMSP_MODE_DIV16 3'h1
`define SMSP_MODE_DIV64 3'h2
`define SMSP_MODE_SUB 3'h3
`define SMSP_MODE_TMR 3'h4
`define SMSP_MODE_SLAVE 3'h5
`define SMSP_DIV4_HALF 6'h01
`define SMSP_DIV16_HALF 6'h07
`define SMSP_DIV64_HALF 6'h1F
`endif

// [hw/smsp_spi_port.v]
// spi port of the serial module: apb registers, master clock generator and shift engine
//
// The address map and the APB interface to the registers are this design's own decisions.
`include "smsp_regs.vh"
module smsp_spi_port (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire sub_clk_tick,
    input wire tmr_match_tick,
    input wire sck_in,
    output reg sck_out,
    output reg sck_oe_n,
    input wire sdi_in,
    output reg sdo_out,
    output reg sdo_oe_n,
    input wire scs_n_in,
    output reg scs_n_out,
    output reg scs_oe_n,
    output reg irq
);
    reg [7:0] ctrl0_r;
    reg [7:0] ctrl2_r;
    reg [7:0] data_r;
    reg [1:0] ien_r;
    reg [2:0] sck_s_r;
    reg [2:0] sdi_s_r;
    reg [2:0] scs_s_r;
    reg [5:0] div_r;
    reg half_r;
    reg [3:0] bits_r;
    reg lead_r;
    reg sck_int_r;
    reg sdo_r;
    reg cap_bit_r;
    reg [7:0] rx_r;
    reg [2:0] cap_dly_r;
    reg [3:0] rxc_r;
    localparam ST_IDLE = 4'b0001;
    localparam ST_MXFER = 4'b0010;
    localparam ST_SXFER = 4'b0100;
    localparam ST_MWAIT = 4'b1000;
    reg [3:0] state_r;

    wire [2:0] mode = ctrl0_r[`SMSP_MODE_HI:`SMSP_MODE_LO];
    wire enable = ctrl0_r[`SMSP_EN_BIT];
    wire idle_lvl = ctrl2_r[`SMSP_IDLE_BIT];
    wire edge_sel = ctrl2_r[`SMSP_EDGE_BIT];
    wire msb_first = ctrl2_r[`SMSP_ORDER_BIT];
    wire select_pin_enable = ctrl2_r[`SMSP_SELECT_PIN_ENABLE_BIT];
    wire is_master = enable && (mode <= `SMSP_MODE_TMR); // RULE_01
    wire is_slave = enable && (mode == `SMSP_MODE_SLAVE); // RULE_02
    // idle level of sck: bit 0 gives high idle
    wire idle_sck = ~idle_lvl; // RULE_10
    // capture on the edge leaving idle when edge_sel is 1, on the edge returning to idle when 0
    // idle high: 0 rising(return to idle), 1 falling; idle low: 0 falling, 1 rising
    wire cap_on_leave = edge_sel; // RULE_21
    wire sck_f = sck_s_r[1];
    wire sck_rise = sck_s_r[1] & ~sck_s_r[2];
    wire sck_fall = ~sck_s_r[1] & sck_s_r[2];
    wire sck_leave = idle_sck ? sck_fall : sck_rise;
    wire sck_back = idle_sck ? sck_rise : sck_fall;
    wire scs_low = ~scs_s_r[1];
    wire scs_rise = scs_s_r[1] & ~scs_s_r[2];
    wire slave_sel = ~select_pin_enable | scs_low; // RULE_23
    wire busy = (state_r != ST_IDLE);
    wire wr = psel & penable & pwrite;
    wire rd = psel & ~pwrite & ~penable;
    wire hit = (paddr == `SMSP_OFS_CTRL0) | (paddr == `SMSP_OFS_CTRL2) |
               (paddr == `SMSP_OFS_DATA) | (paddr == `SMSP_OFS_IEN);
    wire wr_data = wr & (paddr == `SMSP_OFS_DATA);
    wire wr_c0 = wr & (paddr == `SMSP_OFS_CTRL0);
    wire wr_c2 = wr & (paddr == `SMSP_OFS_CTRL2);
    wire start_m = wr_data & ~busy & is_master; // RULE_22
    wire [5:0] half_max = (mode == `SMSP_MODE_DIV4) ? `SMSP_DIV4_HALF :
                          (mode == `SMSP_MODE_DIV16) ? `SMSP_DIV16_HALF : `SMSP_DIV64_HALF;
    // one tick per half period of the bit clock
    wire half_tick = (mode == `SMSP_MODE_SUB) ? sub_clk_tick :
                     (mode == `SMSP_MODE_TMR) ? tmr_match_tick : (div_r == half_max);
    wire tx_bit = msb_first ? data_r[7] : data_r[0]; // RULE_20
    // master events: leading and trailing half-edges of the generated clock
    wire m_edge = (state_r == ST_MXFER) & half_tick;
    wire m_lead = m_edge & ~half_r;
    wire m_trail = m_edge & half_r;
    wire m_cap = cap_on_leave ? m_lead : m_trail;
    wire m_shift = cap_on_leave ? m_trail : m_lead;
    wire s_act = (state_r == ST_SXFER) | ((state_r == ST_IDLE) & is_slave & slave_sel);
    wire s_cap = s_act & slave_sel & (cap_on_leave ? sck_leave : sck_back); // RULE_03
    wire s_shift = s_act & slave_sel & (cap_on_leave ? sck_back : sck_leave);
    wire abort = (state_r == ST_SXFER) & select_pin_enable & scs_rise; // RULE_06
    wire m_done = m_trail & (bits_r == 4'h7);
    // master receive: output register plus two sync stages delay the sdi sample by three cycles
    wire rx_take = cap_dly_r[2];
    wire [7:0] rx_next = msb_first ? {rx_r[6:0], sdi_s_r[1]} : {sdi_s_r[1], rx_r[7:1]};
    wire m_fin = (state_r == ST_MWAIT) & ((rxc_r == 4'h8) | (rx_take & (rxc_r == 4'h7)));
    wire s_done = s_cap & (bits_r == 4'h7) & ~cap_on_leave | s_shift & (bits_r == 4'h8) & cap_on_leave;
    wire done = m_fin | (s_done & (state_r == ST_SXFER)) | abort;
    wire [7:0] shifted = msb_first ? {data_r[6:0], cap_bit_r} : {cap_bit_r, data_r[7:1]}; // RULE_13

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_s_r <= 3'h7;
            sdi_s_r <= 3'h0;
            scs_s_r <= 3'h7;
        end else begin
            sck_s_r <= {sck_s_r[1:0], sck_in};
            sdi_s_r <= {sdi_s_r[1:0], sdi_in};
            scs_s_r <= {scs_s_r[1:0], scs_n_in};
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 6'h00;
        end else if (state_r != ST_MXFER || half_tick) begin
            div_r <= 6'h00;
        end else begin
            div_r <= div_r + 6'h01;
        end
    end

    // apb answers in the access cycle with zero wait
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl0_r <= `SMSP_CTRL0_RST;
            ctrl2_r <= `SMSP_CTRL2_RST;
            ien_r <= 2'h0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit;
            if (rd) begin
                case (paddr)
                    `SMSP_OFS_CTRL0: prdata <= {24'h0, ctrl0_r[7:5], 1'b0, ctrl0_r[3:0]}; // RULE_16
                    `SMSP_OFS_CTRL2: prdata <= {24'h0, ctrl2_r};
                    `SMSP_OFS_DATA: prdata <= {24'h0, data_r}; // RULE_14
                    `SMSP_OFS_IEN: prdata <= {30'h0, ien_r};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
            // control bits kept across enable changes; debounce bits stored only
            if (wr_c0) begin
                ctrl0_r[7:1] <= pwdata[7:1]; // RULE_05 RULE_17
            end
            if (wr_c2) begin
                ctrl2_r[7:2] <= pwdata[7:2]; // RULE_15
            end
            if (wr & (paddr == `SMSP_OFS_IEN)) begin
                ien_r <= pwdata[1:0];
            end
            // flags: hardware set wins over software write
            if (wr_c0) begin
                ctrl0_r[`SMSP_ICF_BIT] <= pwdata[0] & (mode == `SMSP_MODE_SLAVE); // RULE_08 RULE_09
            end
            if (abort) begin
                ctrl0_r[`SMSP_ICF_BIT] <= 1'b1; // RULE_06 RULE_09
            end
            if (wr_c2) begin
                ctrl2_r[`SMSP_WRITE_COLLISION_FLAG_BIT] <= pwdata[1];
                ctrl2_r[`SMSP_TRF_BIT] <= pwdata[0];
            end
            if (wr_data & busy) begin
                ctrl2_r[`SMSP_WRITE_COLLISION_FLAG_BIT] <= 1'b1; // RULE_19
            end
            if (done) begin
                ctrl2_r[`SMSP_TRF_BIT] <= 1'b1; // RULE_18
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            data_r <= `SMSP_DATA_RST;
            bits_r <= 4'h0;
            half_r <= 1'b0;
            sck_int_r <= 1'b1;
            sdo_r <= 1'b1;
            cap_bit_r <= 1'b0;
            lead_r <= 1'b0;
            rx_r <= 8'h00;
            cap_dly_r <= 3'h0;
            rxc_r <= 4'h0;
        end else if (!enable) begin
            state_r <= ST_IDLE; // RULE_04
            cap_dly_r <= 3'h0;
            rxc_r <= 4'h0;
            bits_r <= 4'h0;
            half_r <= 1'b0;
            lead_r <= 1'b0;
            sck_int_r <= idle_sck;
            if (wr_data) begin
                data_r <= pwdata[7:0];
            end
        end else begin
            cap_dly_r <= {cap_dly_r[1:0], m_cap};
            if (rx_take) begin
                rx_r <= rx_next; // RULE_13
                rxc_r <= rxc_r + 4'h1;
            end
            case (state_r)
                ST_IDLE: begin
                    sck_int_r <= idle_sck;
                    bits_r <= 4'h0;
                    half_r <= 1'b0;
                    if (wr_data) begin
                        data_r <= pwdata[7:0]; // RULE_14
                        sdo_r <= msb_first ? pwdata[7] : pwdata[0];
                    end
                    if (start_m) begin
                        state_r <= ST_MXFER; // RULE_12
                        rxc_r <= 4'h0;
                        lead_r <= 1'b0;
                    end else if (is_slave && slave_sel && (s_cap || s_shift)) begin
                        state_r <= ST_SXFER; // RULE_12
                        if (s_cap) begin
                            cap_bit_r <= sdi_s_r[1];
                            bits_r <= 4'h1;
                            lead_r <= 1'b1;
                        end
                    end else if (!wr_data) begin
                        sdo_r <= tx_bit;
                    end
                end
                ST_MXFER: begin
                    if (half_tick) begin
                        half_r <= ~half_r;
                        sck_int_r <= half_r ? idle_sck : ~idle_sck;
                    end
                    if (m_cap) begin
                        cap_bit_r <= sdi_s_r[1];
                        lead_r <= 1'b1;
                    end
                    if (m_shift && lead_r) begin
                        data_r <= shifted;
                        sdo_r <= msb_first ? data_r[6] : data_r[1];
                        lead_r <= 1'b0;
                        bits_r <= bits_r + 4'h1;
                    end
                    if (m_done) begin
                        state_r <= ST_MWAIT;
                    end
                end
                // clock finished; wait for the last delayed sdi sample
                ST_MWAIT: begin
                    if (m_fin) begin
                        data_r <= (rxc_r == 4'h8) ? rx_r : rx_next; // RULE_14
                        state_r <= ST_IDLE;
                    end
                end
                ST_SXFER: begin
                    if (s_cap) begin
                        cap_bit_r <= sdi_s_r[1];
                        lead_r <= 1'b1;
                        if (!cap_on_leave) begin
                            bits_r <= bits_r + 4'h1;
                            data_r <= msb_first ? {data_r[6:0], sdi_s_r[1]} : {sdi_s_r[1], data_r[7:1]};
                            sdo_r <= msb_first ? data_r[6] : data_r[1];
                        end
                    end
                    if (s_shift && lead_r && cap_on_leave) begin
                        data_r <= shifted;
                        sdo_r <= msb_first ? data_r[6] : data_r[1];
                        bits_r <= bits_r + 4'h1;
                        lead_r <= 1'b0;
                    end
                    if (s_done || abort || !is_slave) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // pin drivers: enables are active low while driving
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_out <= 1'b1;
            sck_oe_n <= 1'b1;
            sdo_out <= 1'b1;
            sdo_oe_n <= 1'b1;
            scs_n_out <= 1'b1;
            scs_oe_n <= 1'b1;
            irq <= 1'b0;
        end else begin
            sck_out <= sck_int_r;
            sck_oe_n <= ~is_master; // RULE_03 RULE_04
            sdo_out <= sdo_r;
            sdo_oe_n <= ~(is_master | (is_slave & slave_sel)); // RULE_04
            // master drives select low during a byte when select pin enabled
            scs_n_out <= ~(state_r == ST_MXFER);
            scs_oe_n <= ~(is_master & select_pin_enable); // RULE_11
            irq <= (ien_r[`SMSP_IEN_TRF_BIT] & ctrl2_r[`SMSP_TRF_BIT]) |
                   (ien_r[`SMSP_IEN_ICF_BIT] & ctrl0_r[`SMSP_ICF_BIT]); // RULE_07
        end
    end
endmodule

// [testbench/smsp_spi_port_props.sv]
// assertion checker for the serial module spi port
module smsp_props (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire sck_out,
    input wire sck_oe_n,
    input wire sdo_oe_n,
    input wire scs_n_out,
    input wire scs_oe_n,
    input wire irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] c0_r;
    logic [5:0] c2_r;
    logic [1:0] ien_r;
    logic [6:0] run_r;
    logic sck_r;
    wire wr = psel && penable && pwrite && pready;
    wire mst = c0_r[7:5] < 3'h3 && c0_r[1];
    wire [6:0] half = c0_r[6] ? 7'h20 : c0_r[5] ? 7'h08 : 7'h02;
    // shadow of software settings, run length of sck level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c0_r <= 8'hE0;
            c2_r <= 6'h00;
            ien_r <= 2'h0;
            run_r <= 7'h00;
            sck_r <= 1'h1;
        end else begin
            sck_r <= sck_out;
            run_r <= (sck_out != sck_r) ? 7'h01 : run_r + 7'h01;
            if (wr && paddr == 12'h000) c0_r <= pwdata[7:0];
            if (wr && paddr == 12'h004) c2_r <= pwdata[5:0];
            if (wr && paddr == 12'h00C) ien_r <= pwdata[1:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rdy;
        psel && !penable |=> pready ##1 !pready; endproperty
    a_rdy: assert property (p_rdy) else $error("ready not one cycle after setup");
    property p_bit4;
        pready && !pwrite && paddr == 12'h000 |-> prdata[4] == 1'h0 && prdata[31:8] == 24'h0; endproperty
    a_bit4: assert property (p_bit4) else $error("control 0 spare bits not zero");
    property p_off;
        !c0_r[1] [*3] |-> sck_oe_n && sdo_oe_n && scs_oe_n; endproperty
    a_off: assert property (p_off) else $error("pins driven while disabled");
    property p_idle;
        (scs_n_out && !sck_oe_n && $stable(c2_r[5])) [*4] |-> sck_out == !c2_r[5]; endproperty
    a_idle: assert property (p_idle) else $error("clock not at idle level");
    property p_rate;
        mst && !sck_oe_n && !$past(scs_n_out) && $changed(sck_out) && sck_out == !c2_r[5] |-> run_r == half; endproperty
    a_rate: assert property (p_rate) else $error("wrong half bit period");
    property p_slv;
        c0_r[7:5] > 3'h4 [*3] |-> sck_oe_n && scs_oe_n; endproperty
    a_slv: assert property (p_slv) else $error("slave drives clock or select");
    property p_cs;
        !c2_r[2] [*3] |-> scs_oe_n; endproperty
    a_cs: assert property (p_cs) else $error("select driven while disabled");
    property p_hold;
        irq && !(psel && pwrite) && !$past(psel && pwrite) |=> irq; endproperty
    a_hold: assert property (p_hold) else $error("flag cleared without software");
    property p_done;
        mst && ien_r[0] && $rose(scs_n_out) |-> ##[0:4] irq; endproperty
    a_done: assert property (p_done) else $error("no completion after byte");
    c_byte: cover property (mst && $rose(scs_n_out));
    c_slv: cover property (c0_r[7:5] == 3'h5 && irq);
    c_rate: cover property (mst && $changed(sck_out) && !scs_n_out);
endmodule
bind smsp_spi_port smsp_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .sck_out(sck_out),
    .sck_oe_n(sck_oe_n), .sdo_oe_n(sdo_oe_n), .scs_n_out(scs_n_out), .scs_oe_n(scs_oe_n), .irq(irq));

// [testbench/smsp_peer.sv]
// spi slave device model facing the port in master mode
module smsp_peer (
    input wire logic sck,
    input wire logic scs_n,
    input wire logic sdo,
    input wire logic idle_bit,
    input wire logic edge_sel,
    input wire logic msb_first,
    input wire logic [7:0] tx,
    output logic sdi,
    output logic [7:0] rx
);
    timeunit 1ns;
    timeprecision 1ps;
    int k = 8;
    int c = 8;
    function automatic logic pick(input int i);
        return msb_first ? tx[7 - i] : tx[i];
    endfunction
    initial sdi = 1'h1;
    always @(negedge scs_n) begin
        k = 0;
        c = 0;
        if (edge_sel) begin
            sdi = pick(0);
            k = 1;
        end
    end
    // released line shows the inverse of its last value
    always @(posedge scs_n) sdi = ~sdi;
    always @(sck) begin
        if ((sck == idle_bit) == edge_sel && c < 8) begin
            rx = msb_first ? {rx[6:0], sdo} : {sdo, rx[7:1]};
            c++;
        end else if ((sck == idle_bit) != edge_sel && k < 8) begin
            sdi = pick(k);
            k++;
        end
    end
endmodule

// [testbench/test_serial_module_spi_port.sv]
// self-checking testbench of the serial module spi port
`include "smsp_regs.vh"
module test_serial_module_spi_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, seed = 32'h0000001A;
    logic pready, pslverr, sub_t = 1'h0, tmr_t = 1'h0, sck_out, sck_oe_n, sdo_out, sdo_oe_n, scs_n_out, scs_oe_n, irq;
    logic ext_sck = 1'h1, ext_scs_n = 1'h1, p_sdi, p_idle = 1'h0, p_edge = 1'h0, p_msb = 1'h0;
    logic [7:0] p_tx = 8'h00, p_rx, tx;
    logic [2:0] tc = 3'h0;
    logic [32:0] qe[$], qm[$];
    int err_count = 0, tests_run = 0;
    wire sck_in = sck_oe_n ? ext_sck : sck_out;
    wire scs_n_in = scs_oe_n ? ext_scs_n : scs_n_out;
    always #20 pclk = ~pclk;
    always @(posedge pclk) begin
        tc <= tc + 3'h1;
        sub_t <= tc[1:0] == 2'h0;
        tmr_t <= tc == 3'h0;
    end
    smsp_spi_port uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sub_clk_tick(sub_t), .tmr_match_tick(tmr_t), .sck_in(sck_in), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
        .sdi_in(p_sdi), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .scs_n_in(scs_n_in), .scs_n_out(scs_n_out),
        .scs_oe_n(scs_oe_n), .irq(irq));
    smsp_peer peer (.sck(sck_out), .scs_n(scs_n_out), .sdo(sdo_out), .idle_bit(p_idle), .edge_sel(p_edge),
        .msb_first(p_msb), .tx(p_tx), .sdi(p_sdi), .rx(p_rx));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    task automatic chk(input string n, input logic [32:0] got, input logic [32:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", n, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e, m);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        if (!w) begin
            qe.push_back(e);
            qm.push_back(m);
        end
        do @(posedge pclk); while (pready !== 1'h1);
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
        apb(1'h0, a, 32'h0, {25'h0, e & m}, {25'h1FFFFFF, m});
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'h1, a, {24'h0, d}, 33'h0, 33'h0);
    endtask
    task automatic pulses(input int k);
        repeat (k) begin
            repeat (8) @(posedge pclk);
            ext_sck <= 1'h0;
            repeat (8) @(posedge pclk);
            ext_sck <= 1'h1;
        end
    endtask
    task stop_test;
        if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && qe.size() > 0)
            chk($sformatf("read %h", paddr), {pslverr, prdata} & qm.pop_front(), qe.pop_front());
    end
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        stop_test;
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        rd(`SMSP_OFS_CTRL0, 8'hE0);
        rd(`SMSP_OFS_CTRL2, 8'h00);
        apb(1'h0, 12'h010, 32'h0, {1'h1, 32'h0}, {33{1'h1}});
        wr(`SMSP_OFS_CTRL2, 8'hC0);
        wr(`SMSP_OFS_CTRL0, 8'hFE);
        rd(`SMSP_OFS_CTRL0, 8'hEE);
        rd(`SMSP_OFS_CTRL2, 8'hC0);
        wr(`SMSP_OFS_IEN, 8'h03);
        for (int i = 0; i < 10; i++) begin
            seed = xs(seed);
            tx = seed[7:0];
            p_tx <= seed[15:8];
            p_idle <= i[0];
            p_edge <= i[1];
            p_msb <= i[2];
            wr(`SMSP_OFS_CTRL2, {2'h0, i[0], i[1], i[2], 3'h4});
            wr(`SMSP_OFS_CTRL0, {3'(i % 5), 1'h0, seed[17:16], 2'h2});
            wr(`SMSP_OFS_DATA, tx);
            wr(`SMSP_OFS_DATA, ~tx);
            while (irq !== 1'h1) @(posedge pclk);
            repeat (2) @(posedge pclk);
            chk("peer rx", {25'h0, p_rx}, {25'h0, tx});
            rd(`SMSP_OFS_DATA, p_tx);
            rd(`SMSP_OFS_CTRL2, {2'h0, i[0], i[1], i[2], 3'h7});
            wr(`SMSP_OFS_CTRL2, {2'h0, i[0], i[1], i[2], 3'h4});
            @(posedge pclk);
            chk("irq", {32'h0, irq}, 33'h0);
        end
        wr(`SMSP_OFS_CTRL0, 8'h00);
        repeat (3) @(posedge pclk);
        chk("pins off", {30'h0, sck_oe_n, sdo_oe_n, scs_oe_n}, 33'h7);
        wr(`SMSP_OFS_CTRL0, 8'h03);
        rd(`SMSP_OFS_CTRL0, 8'h02);
        wr(`SMSP_OFS_CTRL2, 8'h0C);
        wr(`SMSP_OFS_CTRL0, 8'hA2);
        pulses(8);
        rd(`SMSP_OFS_CTRL2, 8'h00, 8'h01);
        repeat (4) @(posedge pclk);
        ext_scs_n <= 1'h0;
        pulses(3);
        ext_scs_n <= 1'h1;
        repeat (8) @(posedge pclk);
        rd(`SMSP_OFS_CTRL0, 8'hA3);
        rd(`SMSP_OFS_CTRL2, 8'h0D);
        chk("irq", {32'h0, irq}, 33'h1);
        wr(`SMSP_OFS_CTRL2, 8'h0C);
        wr(`SMSP_OFS_CTRL0, 8'hA2);
        wr(`SMSP_OFS_CTRL0, 8'hA3);
        rd(`SMSP_OFS_CTRL2, 8'h0C);
        stop_test;
    end
endmodule
